// file: hdl/exc_pkg.sv
// Purpose: shared types and constants of the exception entry block.
// Assumes: one CPU clock shared with decoder, break and interrupt units.
// Notes: status word layout, register offsets and event codes live here.
// Summary of operation
// - Reserved instruction: save, code 180, vector 100.
// - Top opcode nibble F means undefined instruction.
// - Control, return, TLB-load, sleep privileged; global base not.
// - Bad delay-slot instruction: code 1A0, branch PC, own PC if condition false.
// - Branches, trap, status loads illegal in slot.
// - Break saves next, target or own PC, code 1E0.
// - NMI edge: code 1C0, vector 600.
// - NMI ignores mask, wins, held by block.
// - External level taken when above mask, unblocked.
// - External code 200 plus level times 20.
// - On-chip source taken when priority exceeds mask.
// - Interrupt saves next or target PC and current status.
// - Block bit holds interrupts until cleared.
// - Sleep accepts interrupts despite block bit.
// - Blocked: no break; others jump to reset.
// - Return loads PC and status from saved copies.
// - Re-executing faults save own or branch PC.
// - Completed faults save next or target PC.
// - Reset: base zero, bits set, mask F.
// - Entry sets block, privilege and bank bits.
package exc_pkg;
  // Register byte offsets, low address bits only.
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_VBASE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SAVED_PC = 8'h08;
  localparam logic [7:0] OFS_SAVED_ST = 8'h0c;
  localparam logic [7:0] OFS_EXC_CODE = 8'h10;
  localparam logic [7:0] OFS_INT_CODE = 8'h14;
  // Status word field positions.
  localparam int ST_PRIV = 30;
  localparam int ST_BANK = 29;
  localparam int ST_BLOCK = 28;
  localparam int ST_MASK = 4;
  localparam logic [31:0] ENTRY_BITS = 32'h7000_0000;
  localparam logic [31:0] STATUS_RST = 32'h7000_00f0;
  localparam logic [31:0] VBASE_RST = 32'h0000_0000;
  localparam logic [31:0] RESET_PC = 32'ha000_0000;
  // Vector offsets and event codes.
  localparam logic [31:0] VEC_EXC = 32'h0000_0100;
  localparam logic [31:0] VEC_INT = 32'h0000_0600;
  localparam logic [11:0] EXP_RESV = 12'h180;
  localparam logic [11:0] EXP_SLOT = 12'h1a0;
  localparam logic [11:0] EXP_BRK = 12'h1e0;
  localparam logic [11:0] INT_NMI = 12'h1c0;
  localparam logic [11:0] LVL_BASE = 12'h200;
  localparam logic [11:0] LVL_STEP = 12'h020;
  localparam logic [3:0] UNDEF_NIB = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {BS_IDLE = 1'b0, BS_BUSY = 1'b1} bus_st_t;
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0, SRC_NMI = 2'h1, SRC_LVL = 2'h2, SRC_CHIP = 2'h3
  } src_t;
  typedef struct packed {
    logic [31:0] awaddr; logic awvalid;
    logic [31:0] wdata; logic [3:0] wstrb; logic wvalid;
    logic bready;
    logic [31:0] araddr; logic arvalid; logic rready;
  } axi_req_t;
  typedef struct packed {
    logic awready; logic wready;
    logic [1:0] bresp; logic bvalid;
    logic arready; logic [31:0] rdata; logic [1:0] rresp; logic rvalid;
  } axi_rsp_t;
  typedef struct packed {
    logic valid; logic [15:0] opcode; logic in_slot;
    logic ctrl_ld; logic ctrl_st; logic ctrl_gbase;
    logic ret_exc; logic tlb_ld; logic sleep; logic pc_write;
    logic dly_cond; logic cond_false;
    logic [31:0] pc; logic [31:0] next_pc;
    logic [31:0] branch_pc; logic [31:0] target_pc;
  } instr_t;
  typedef struct packed {logic req; logic post;} brk_t;
  typedef struct packed {
    logic req; logic [3:0] prio; logic [11:0] code;
  } onchip_t;
  typedef struct packed {logic valid; logic [31:0] pc;} redir_t;
  typedef struct packed {
    logic priv; logic bank; logic block; logic [3:0] mask;
  } stat_t;
  typedef struct packed {logic valid; src_t src;} ack_t;
endpackage

// file: hdl/exc_entry.sv
// Purpose: exception and interrupt entry, return and reset state.
// Assumes: decoder presents one instruction boundary per valid cycle.
// Notes: hardware updates win over bus writes in the same cycle.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module exc_entry (
  // Clock and reset.
  input logic MCLK,
  input logic RST_N,
  // Register bus.
  input exc_pkg::axi_req_t AXI_REQ,
  output exc_pkg::axi_rsp_t AXI_RSP,
  // Decoder, break and interrupt controller.
  input exc_pkg::instr_t INSTR,
  input exc_pkg::brk_t BRK,
  input exc_pkg::onchip_t ONCHIP,
  input logic SLEEP_MODE,
  // Asynchronous pins.
  input logic NMI_PIN,
  input logic [3:0] LVL_PIN,
  // Results.
  output exc_pkg::redir_t REDIRECT,
  output exc_pkg::stat_t STATUS,
  output exc_pkg::ack_t INT_ACK
);
  import exc_pkg::*;

  // Whole state of the block in one record.
  typedef struct packed {
    logic [31:0] vbase;
    logic [31:0] stw;
    logic [31:0] saved_pc;
    logic [31:0] saved_st;
    logic [11:0] exc_ev;
    logic [11:0] int_ev;
    logic [1:0] nmi_s;
    logic nmi_l;
    logic nmi_pend;
    logic [3:0] lvl_m;
    logic [3:0] lvl_s;
    logic redir;
    logic [31:0] rpc;
    logic ack;
    src_t src;
    bus_st_t ws;
    bus_st_t rs;
    logic aw_ok;
    logic w_ok;
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] wbe;
    logic [1:0] bresp;
    logic [31:0] rdat;
    logic [1:0] rresp;
  } st_t;

  // State register and its next value.
  st_t s_q;
  st_t s_d;
  // Decoded status and instruction classes.
  logic blk;
  logic prv;
  logic [3:0] mask;
  logic undef;
  logic priv;
  logic upriv;
  logic slot_ill;
  logic resv;
  logic brk_go;
  logic multi;
  logic exc_go;
  logic ret_go;
  // Interrupt qualification terms.
  logic bound;
  logic nmi_edge;
  logic nmi_take;
  logic lvl_take;
  logic oc_take;
  logic int_go;
  logic sel_lvl;
  // Codes, saved program counters and bus strobes.
  logic [11:0] exc_code;
  logic [11:0] int_code;
  logic [31:0] reexec_pc;
  logic [31:0] done_pc;
  logic [31:0] exc_pc;
  logic aw_hs;
  logic w_hs;

  // Byte-lane merge of a bus write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[8*k+:8] = nw[8*k+:8];
      end
    end
    return r;
  endfunction

  // Current status fields.
  assign blk = s_q.stw[ST_BLOCK];
  assign prv = s_q.stw[ST_PRIV];
  assign mask = s_q.stw[ST_MASK+:4];

  // Instruction classification at the boundary.
  assign undef = INSTR.opcode[15:12] == UNDEF_NIB;
  assign priv = ((INSTR.ctrl_ld | INSTR.ctrl_st) & ~INSTR.ctrl_gbase)
    | INSTR.ret_exc | INSTR.tlb_ld | INSTR.sleep;
  assign upriv = priv & ~prv;
  assign slot_ill = INSTR.valid & INSTR.in_slot
    & (undef | INSTR.pc_write | upriv);
  assign resv = INSTR.valid & ~INSTR.in_slot & (undef | upriv);
  assign brk_go = INSTR.valid & BRK.req & ~blk;
  assign multi = blk & (slot_ill | resv);
  assign exc_go = ~blk & (slot_ill | resv | brk_go);
  // A handler returns with the block bit set, so return ignores it.
  assign ret_go = INSTR.valid & INSTR.ret_exc & ~(slot_ill | resv)
    & ~brk_go;

  // Saved program counter selection.
  assign reexec_pc = INSTR.in_slot
    ? (INSTR.cond_false ? INSTR.pc : INSTR.branch_pc)
    : INSTR.pc;
  assign done_pc = INSTR.dly_cond
    ? (INSTR.cond_false ? INSTR.next_pc : INSTR.target_pc)
    : INSTR.next_pc;
  assign exc_pc = (slot_ill | resv) ? reexec_pc
    : (BRK.post ? done_pc : INSTR.pc);
  assign exc_code = slot_ill ? EXP_SLOT
    : (resv ? EXP_RESV : EXP_BRK);

  // Interrupt qualification; sleep overrides the block bit.
  assign bound = (INSTR.valid | SLEEP_MODE)
    & (~blk | SLEEP_MODE);
  assign nmi_edge = s_q.nmi_s[1] & ~s_q.nmi_l;
  assign nmi_take = s_q.nmi_pend;
  assign lvl_take = s_q.lvl_s > mask;
  assign oc_take = ONCHIP.req & (ONCHIP.prio > mask);
  assign int_go = bound & ~multi & ~exc_go & ~ret_go
    & (nmi_take | lvl_take | oc_take);
  assign sel_lvl = lvl_take & (~oc_take | s_q.lvl_s >= ONCHIP.prio);
  assign int_code = nmi_take ? INT_NMI
    : (sel_lvl ? LVL_BASE + 12'(s_q.lvl_s) * LVL_STEP
    : ONCHIP.code);

  // Bus handshakes.
  assign aw_hs = AXI_REQ.awvalid & AXI_RSP.awready;
  assign w_hs = AXI_REQ.wvalid & AXI_RSP.wready;

  // Next state: synchronisers, bus slave, then entry and return.
  always_comb begin
    s_d = s_q;
    s_d.redir = 1'b0;
    s_d.ack = 1'b0;
    s_d.nmi_s = {s_q.nmi_s[0], NMI_PIN};
    s_d.nmi_l = s_q.nmi_s[1];
    s_d.lvl_m = LVL_PIN;
    s_d.lvl_s = s_q.lvl_m;
    // A new edge is kept even in the cycle the old one is taken.
    s_d.nmi_pend = nmi_edge | (s_q.nmi_pend & ~(int_go & nmi_take));
    if (aw_hs) begin
      s_d.aw_ok = 1'b1;
      s_d.wa = AXI_REQ.awaddr[ADDR_W-1:0];
    end
    if (w_hs) begin
      s_d.w_ok = 1'b1;
      s_d.wd = AXI_REQ.wdata;
      s_d.wbe = AXI_REQ.wstrb;
    end
    if (s_q.ws == BS_IDLE && s_q.aw_ok && s_q.w_ok) begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.ws = BS_BUSY;
      s_d.bresp = RESP_OKAY;
      case (s_q.wa)
        OFS_VBASE: s_d.vbase = merge(s_q.vbase, s_q.wd, s_q.wbe);
        OFS_STATUS: s_d.stw = merge(s_q.stw, s_q.wd, s_q.wbe);
        OFS_SAVED_PC: s_d.saved_pc = merge(s_q.saved_pc, s_q.wd, s_q.wbe);
        OFS_SAVED_ST: s_d.saved_st = merge(s_q.saved_st, s_q.wd, s_q.wbe);
        OFS_EXC_CODE, OFS_INT_CODE: s_d.bresp = RESP_OKAY;
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end else if (s_q.ws == BS_BUSY && AXI_REQ.bready) begin
      s_d.ws = BS_IDLE;
    end
    if (s_q.rs == BS_IDLE && AXI_REQ.arvalid) begin
      s_d.rs = BS_BUSY;
      s_d.rresp = RESP_OKAY;
      case (AXI_REQ.araddr[ADDR_W-1:0])
        OFS_VBASE: s_d.rdat = s_q.vbase;
        OFS_STATUS: s_d.rdat = s_q.stw;
        OFS_SAVED_PC: s_d.rdat = s_q.saved_pc;
        OFS_SAVED_ST: s_d.rdat = s_q.saved_st;
        OFS_EXC_CODE: s_d.rdat = {20'h00000, s_q.exc_ev};
        OFS_INT_CODE: s_d.rdat = {20'h00000, s_q.int_ev};
        default: begin
          s_d.rdat = 32'h0000_0000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rs == BS_BUSY && AXI_REQ.rready) begin
      s_d.rs = BS_IDLE;
    end
    // Entry and return override bus writes to the registers they load in the same cycle.
    if (multi) begin
      s_d.redir = 1'b1;
      s_d.rpc = RESET_PC;
    end else if (exc_go) begin
      s_d.saved_st = s_q.stw;
      s_d.stw = s_q.stw | ENTRY_BITS;
      s_d.saved_pc = exc_pc;
      s_d.exc_ev = exc_code;
      s_d.redir = 1'b1;
      s_d.rpc = s_q.vbase + VEC_EXC;
    end else if (ret_go) begin
      s_d.stw = s_q.saved_st;
      s_d.redir = 1'b1;
      s_d.rpc = s_q.saved_pc;
    end else if (int_go) begin
      s_d.saved_st = s_q.stw;
      s_d.stw = s_q.stw | ENTRY_BITS;
      s_d.saved_pc = done_pc;
      s_d.int_ev = int_code;
      s_d.redir = 1'b1;
      s_d.rpc = s_q.vbase + VEC_INT;
      s_d.ack = 1'b1;
      s_d.src = nmi_take ? SRC_NMI : (sel_lvl ? SRC_LVL : SRC_CHIP);
    end
  end

  // State register with reset values.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.vbase <= VBASE_RST;
      s_q.stw <= STATUS_RST;
      s_q.redir <= 1'b1;
      s_q.rpc <= RESET_PC;
      s_q.src <= SRC_NONE;
      s_q.ws <= BS_IDLE;
      s_q.rs <= BS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Output assembly.
  assign REDIRECT = '{valid: s_q.redir, pc: s_q.rpc};
  assign STATUS = '{priv: s_q.stw[ST_PRIV], bank: s_q.stw[ST_BANK],
    block: s_q.stw[ST_BLOCK], mask: s_q.stw[ST_MASK+:4]};
  assign INT_ACK = '{valid: s_q.ack, src: s_q.src};
  assign AXI_RSP = '{
    awready: s_q.ws == BS_IDLE && !s_q.aw_ok,
    wready: s_q.ws == BS_IDLE && !s_q.w_ok,
    bresp: s_q.bresp, bvalid: s_q.ws == BS_BUSY,
    arready: s_q.rs == BS_IDLE, rdata: s_q.rdat,
    rresp: s_q.rresp, rvalid: s_q.rs == BS_BUSY};

  // Checks on entry, return and masking.
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  // Reserved code outside a slot enters at the exception vector.
  a_resv_entry: assert property (resv && !blk |=>
    s_q.exc_ev == EXP_RESV && s_q.redir
    && s_q.rpc == $past(s_q.vbase) + VEC_EXC)
    else $error("reserved entry wrong");

  // An opcode with the top nibble set always counts as undefined.
  a_undef_nibble: assert property (INSTR.valid && !INSTR.in_slot
    && INSTR.opcode[15:12] == 4'hf && !blk |=> s_q.exc_ev == EXP_RESV)
    else $error("undefined opcode missed");

  // A user-mode table load traps and leaves privileged mode set.
  a_user_tlb: assert property (INSTR.valid && !INSTR.in_slot
    && INSTR.tlb_ld && !prv && !blk |=> s_q.stw[ST_PRIV] && s_q.redir)
    else $error("user privileged not trapped");

  // A bad slot instruction saves the branch state and the old status.
  a_slot_pc: assert property (slot_ill && !blk |=>
    s_q.exc_ev == EXP_SLOT && s_q.saved_pc == $past(reexec_pc)
    && s_q.saved_st == $past(s_q.stw))
    else $error("slot entry wrong");

  // Any program counter write in a slot is an illegal slot case.
  a_slot_write: assert property (INSTR.valid && INSTR.in_slot
    && INSTR.pc_write && !blk |=> s_q.exc_ev == EXP_SLOT && s_q.redir)
    else $error("slot branch not trapped");

  // A break saves its own or the completed program counter.
  a_brk_pc: assert property (brk_go && !slot_ill && !resv |=>
    s_q.saved_pc == ($past(BRK.post) ? $past(done_pc) : $past(INSTR.pc)))
    else $error("break saved pc wrong");

  // The edge interrupt enters at the interrupt vector with its code.
  a_nmi_code: assert property (int_go && nmi_take |=>
    s_q.int_ev == INT_NMI && s_q.src == SRC_NMI
    && s_q.rpc == $past(s_q.vbase) + VEC_INT)
    else $error("nmi entry wrong");

  // A blocked edge interrupt stays pending rather than being lost.
  a_nmi_block: assert property (nmi_take && blk && !SLEEP_MODE
    |=> s_q.nmi_pend)
    else $error("blocked nmi dropped");

  // A level is only taken when it is above the mask.
  a_lvl_mask: assert property (INT_ACK.valid
    && INT_ACK.src == SRC_LVL |-> $past(s_q.lvl_s) > $past(mask))
    else $error("level taken under mask");

  // The level code steps by a fixed amount and the mask is kept.
  a_lvl_code: assert property (INT_ACK.valid
    && INT_ACK.src == SRC_LVL
    |-> s_q.int_ev == LVL_BASE + 12'($past(s_q.lvl_s)) * LVL_STEP
    && s_q.stw[ST_MASK+:4] == $past(mask))
    else $error("level code wrong");

  // An on-chip source hands its own code to the event register.
  a_chip_code: assert property (int_go && !nmi_take && !sel_lvl
    |=> s_q.int_ev == $past(ONCHIP.code) && s_q.src == SRC_CHIP)
    else $error("on-chip code wrong");

  // An interrupt saves the following address and the current status.
  a_int_save: assert property (int_go && !INSTR.dly_cond
    |=> s_q.saved_pc == $past(INSTR.next_pc)
    && s_q.saved_st == $past(s_q.stw))
    else $error("interrupt save wrong");

  // Nothing is acknowledged while blocked outside sleep.
  a_block_hold: assert property (blk && !SLEEP_MODE |=> !s_q.ack)
    else $error("interrupt taken while blocked");

  // Sleep lets a qualifying interrupt through the block bit.
  a_sleep_take: assert property (SLEEP_MODE && blk && !multi
    && !ret_go && (nmi_take || lvl_take || oc_take) |=> s_q.ack)
    else $error("sleep interrupt not taken");

  // A blocked break raises no redirect of its own.
  a_brk_block: assert property (BRK.req && blk && !SLEEP_MODE
    && !multi && !ret_go |=> !s_q.redir)
    else $error("blocked break taken");

  // Entry sets block, privilege and bank and keeps the mask.
  a_entry_bits: assert property ($rose(s_q.ack) |->
    s_q.stw[ST_BLOCK] && s_q.stw[ST_PRIV] && s_q.stw[ST_BANK]
    && s_q.stw[ST_MASK+:4] == $past(mask))
    else $error("entry status bits wrong");

  // Return restores status and resumes at the saved address.
  a_rte_load: assert property (ret_go |=>
    s_q.stw == $past(s_q.saved_st)
    && s_q.rpc == $past(s_q.saved_pc) && s_q.redir)
    else $error("return load wrong");

  // A re-executing fault outside a slot saves its own address.
  a_reexec_pc: assert property (resv && !blk
    |=> s_q.saved_pc == $past(INSTR.pc))
    else $error("re-executing pc wrong");

  // A taken conditional delayed branch saves its target.
  a_dly_target: assert property (int_go && INSTR.dly_cond
    && !INSTR.cond_false |=> s_q.saved_pc == $past(INSTR.target_pc))
    else $error("delayed target not saved");

  // A fault while blocked goes to the reset address and keeps codes.
  a_multi_reset: assert property (multi |=> s_q.redir
    && s_q.rpc == RESET_PC && $stable(s_q.exc_ev))
    else $error("blocked exception not to reset");
endmodule

// file: tb/onchip_model.sv
// Purpose: stands in for the interrupt controller's on-chip source.
// Assumes: the bench commands each request with a one-cycle raise.
// Notes: a request stays up until the block acknowledges it.
`timescale 1ns/1ps
module onchip_model (
  // Clock and reset.
  input logic clk,
  input logic rst_n,
  // Command from the bench.
  input logic raise,
  input logic [3:0] prio,
  input logic [11:0] code,
  // Link to the block.
  input exc_pkg::ack_t ack,
  output exc_pkg::onchip_t req
);
  import exc_pkg::*;

  onchip_t req_q;

  // Hold the request until acknowledged; stale fields are inverted after.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= '0;
    end else if (ack.valid && ack.src == SRC_CHIP) begin
      req_q <= {1'b0, ~req_q.prio, ~req_q.code};
    end else if (raise) begin
      req_q <= {1'b1, prio, code};
    end
  end

  // The request leaves straight from the register.
  assign req = req_q;
endmodule

// file: tb/exc_entry_tb.sv
// Purpose: self-checking bench of the exception entry block.
// Assumes: answers follow the hand-over timing of the block.
// Notes: handshakes are sampled at the falling edge before they count.
`timescale 1ns/1ps
module exc_entry_tb;
  import exc_pkg::*;
  localparam logic [31:0] VB = 32'h8000_0000;
  localparam logic [31:0] ST_P = 32'h4000_0030;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  axi_req_t rq = '0;
  axi_rsp_t rs;
  instr_t ins = '0;
  brk_t brk = '0;
  onchip_t oc;
  logic sleep = 1'b0;
  logic nmi = 1'b0;
  logic [3:0] lvl = 4'h0;
  redir_t rd;
  stat_t st;
  ack_t ak;
  logic raise = 1'b0;
  logic [3:0] cprio = 4'h0;
  logic [11:0] ccode = 12'h400;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;

  exc_entry dut_u (.MCLK(mclk), .RST_N(rst_n), .AXI_REQ(rq), .AXI_RSP(rs),
    .INSTR(ins), .BRK(brk), .ONCHIP(oc), .SLEEP_MODE(sleep),
    .NMI_PIN(nmi), .LVL_PIN(lvl), .REDIRECT(rd), .STATUS(st), .INT_ACK(ak));
  onchip_model src_u (.clk(mclk), .rst_n(rst_n), .raise(raise),
    .prio(cprio), .code(ccode), .ack(ak), .req(oc));

  // Clock of 20 ns.
  initial begin
    forever #10 mclk = ~mclk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // The whole run needs a few hundred cycles.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      summarize();
    end
  end

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    logic b;
    @(posedge mclk);
    rq.awaddr <= {24'h0, a};
    rq.wdata <= d;
    rq.wstrb <= 4'hf;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    do begin
      @(negedge mclk);
      aw = rq.awvalid & rs.awready;
      w = rq.wvalid & rs.wready;
      b = rs.bvalid;
      @(posedge mclk);
      if (aw) rq.awvalid <= 1'b0;
      if (w) rq.wvalid <= 1'b0;
    end while (!b);
    rq.bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er, input string n);
    logic ar;
    logic r;
    logic [31:0] d;
    logic [1:0] p;
    @(posedge mclk);
    rq.araddr <= {24'h0, a};
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do begin
      @(negedge mclk);
      ar = rq.arvalid & rs.arready;
      r = rs.rvalid;
      d = rs.rdata;
      p = rs.rresp;
      @(posedge mclk);
      if (ar) rq.arvalid <= 1'b0;
    end while (!r);
    rq.rready <= 1'b0;
    chk(n, d, e);
    chk(n, {30'h0, p}, {30'h0, er});
  endtask

  function automatic instr_t mk(input logic [15:0] op, input logic [31:0] pc);
    mk = '0;
    mk.valid = 1'b1;
    mk.opcode = op;
    mk.pc = pc;
    mk.next_pc = pc + 32'h2;
    mk.branch_pc = pc - 32'h2;
    mk.target_pc = pc + 32'h100;
  endfunction

  // One completing instruction, then the redirect of the next cycle.
  task automatic step(input instr_t i, input brk_t b, input logic v,
                      input logic [31:0] pc);
    @(posedge mclk);
    ins <= i;
    brk <= b;
    @(posedge mclk);
    ins.valid <= 1'b0;
    brk <= '0;
    @(negedge mclk);
    chk("redirect valid", {31'h0, rd.valid}, {31'h0, v});
    if (v) chk("redirect pc", rd.pc, pc);
  endtask

  task automatic t_reset();
    chk("status", {25'h0, st}, 32'h7f);
    rdr(OFS_VBASE, VBASE_RST, RESP_OKAY, "vbase");
    rdr(OFS_STATUS, STATUS_RST, RESP_OKAY, "status");
    rdr(8'h18, 32'h0, RESP_SLVERR, "unmapped");
    step(mk(16'hf000, 32'h100), '0, 1'b1, RESET_PC);
    step(mk(16'h0009, 32'h100), brk_t'(2'b10), 1'b0, 32'h0);
    wr(OFS_EXC_CODE, 32'hfff);
    rdr(OFS_EXC_CODE, 32'h0, RESP_OKAY, "read only");
    wr(OFS_VBASE, VB);
    $display("test reset done");
  endtask

  task automatic t_resv();
    instr_t i;
    wr(OFS_STATUS, ST_P);
    step(mk(16'hf123, 32'h1000), '0, 1'b1, VB + VEC_EXC);
    chk("entry", {29'h0, st.priv, st.bank, st.block}, 32'h7);
    rdr(OFS_EXC_CODE, {20'h0, EXP_RESV}, RESP_OKAY, "code");
    rdr(OFS_SAVED_PC, 32'h1000, RESP_OKAY, "saved pc");
    rdr(OFS_SAVED_ST, ST_P, RESP_OKAY, "saved status");
    // Each privileged kind in user mode, then a global base load.
    for (int k = 0; k < 6; k++) begin
      i = mk(16'h4000, 32'h1200);
      {i.ctrl_ld, i.ctrl_st, i.ret_exc, i.tlb_ld, i.sleep} = 5'h10 >> k;
      if (k == 5) {i.ctrl_ld, i.ctrl_gbase} = 2'b11;
      wr(OFS_STATUS, 32'h30);
      step(i, '0, k < 5, VB + VEC_EXC);
    end
    $display("test reserved done");
  endtask

  task automatic t_slot();
    instr_t i;
    for (int k = 0; k < 3; k++) begin
      i = mk((k == 2) ? 16'hf000 : 16'h4000, 32'h2000);
      i.in_slot = 1'b1;
      i.pc_write = (k != 2);
      i.dly_cond = (k == 1);
      i.cond_false = (k == 1);
      wr(OFS_STATUS, ST_P);
      step(i, '0, 1'b1, VB + VEC_EXC);
      rdr(OFS_EXC_CODE, {20'h0, EXP_SLOT}, RESP_OKAY, "code");
      rdr(OFS_SAVED_PC, (k == 1) ? 32'h2000 : 32'h1ffe, RESP_OKAY,
          "saved pc");
    end
    $display("test slot done");
  endtask

  task automatic t_brk();
    instr_t i;
    logic [31:0] e;
    // Pre break, post break, then post break on a taken delayed branch.
    for (int k = 0; k < 3; k++) begin
      i = mk(16'h0009, 32'h3000);
      i.dly_cond = (k == 2);
      e = (k == 0) ? 32'h3000 : ((k == 1) ? 32'h3002 : 32'h3100);
      wr(OFS_STATUS, ST_P);
      step(i, {1'b1, k != 0}, 1'b1, VB + VEC_EXC);
      rdr(OFS_EXC_CODE, {20'h0, EXP_BRK}, RESP_OKAY, "code");
      rdr(OFS_SAVED_PC, e, RESP_OKAY, "saved pc");
    end
    $display("test break done");
  endtask

  task automatic t_irl();
    wr(OFS_STATUS, ST_P);
    lvl <= 4'h3;
    repeat (4) @(posedge mclk);
    step(mk(16'h0009, 32'h4000), '0, 1'b0, 32'h0);
    lvl <= 4'h5;
    repeat (4) @(posedge mclk);
    step(mk(16'h0009, 32'h4000), '0, 1'b1, VB + VEC_INT);
    chk("ack", {29'h0, ak}, {29'h0, 1'b1, SRC_LVL});
    chk("mask", {28'h0, st.mask}, 32'h3);
    rdr(OFS_INT_CODE, 32'h2a0, RESP_OKAY, "code");
    rdr(OFS_SAVED_PC, 32'h4002, RESP_OKAY, "saved pc");
    rdr(OFS_SAVED_ST, ST_P, RESP_OKAY, "saved status");
    step(mk(16'h0009, 32'h4100), '0, 1'b0, 32'h0);
    @(posedge mclk);
    sleep <= 1'b1;
    @(posedge mclk);
    sleep <= 1'b0;
    @(negedge mclk);
    chk("sleep take", {31'h0, rd.valid}, 32'h1);
    wr(OFS_STATUS, ST_P);
    step(mk(16'h0009, 32'h4200), '0, 1'b1, VB + VEC_INT);
    lvl <= 4'h0;
    $display("test level done");
  endtask

  task automatic t_rte();
    instr_t i;
    i = mk(16'h002b, 32'h5000);
    i.ret_exc = 1'b1;
    // Unblocked return, then the handler's usual blocked return.
    for (int k = 0; k < 2; k++) begin
      wr(OFS_STATUS, k ? 32'h5000_0000 : ST_P);
      wr(OFS_SAVED_PC, 32'h5550);
      wr(OFS_SAVED_ST, 32'h4000_0020);
      // The return's delay slot never carries a faulting instruction.
      step(i, '0, 1'b1, 32'h5550);
      chk("status", {25'h0, st}, 32'h42);
    end
    $display("test return done");
  endtask

  task automatic t_nmi();
    wr(OFS_STATUS, 32'h5000_00f0);
    nmi <= 1'b1;
    repeat (5) @(posedge mclk);
    step(mk(16'h0009, 32'h6000), '0, 1'b0, 32'h0);
    wr(OFS_STATUS, 32'h4000_00f0);
    step(mk(16'h0009, 32'h6000), '0, 1'b1, VB + VEC_INT);
    chk("ack", {29'h0, ak}, {29'h0, 1'b1, SRC_NMI});
    rdr(OFS_INT_CODE, {20'h0, INT_NMI}, RESP_OKAY, "code");
    nmi <= 1'b0;
    $display("test nmi done");
  endtask

  task automatic t_chip();
    wr(OFS_STATUS, ST_P);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      cprio <= 4'h3 + k[3:0];
      raise <= 1'b1;
      @(posedge mclk);
      raise <= 1'b0;
      step(mk(16'h0009, 32'h7000), '0, k[0], VB + VEC_INT);
    end
    chk("ack", {29'h0, ak}, {29'h0, 1'b1, SRC_CHIP});
    rdr(OFS_INT_CODE, 32'h400, RESP_OKAY, "code");
    $display("test onchip done");
  endtask

  // Reset, then every scenario in turn.
  initial begin
    repeat (8) @(posedge mclk);
    chk("reset pc", rd.pc, RESET_PC);
    rst_n <= 1'b1;
    t_reset();
    t_resv();
    t_slot();
    t_brk();
    t_irl();
    t_rte();
    t_nmi();
    t_chip();
    summarize();
  end
endmodule
